// [rtl/uhie_pkg.sv]
package uhie_pkg;

    localparam int unsigned     UHIE_DATA_W      = 32;
    localparam int unsigned     UHIE_ADDR_W      = 8;

    // register byte offsets from the function's memory base
    localparam logic [7:0]      UHIE_OFS_STATUS  = 8'h0c;
    localparam logic [7:0]      UHIE_OFS_EN_SET  = 8'h10;
    localparam logic [7:0]      UHIE_OFS_EN_CLR  = 8'h14;

    // enable field positions
    localparam int unsigned     UHIE_BIT_MASTER  = 31;
    localparam int unsigned     UHIE_BIT_OWNER   = 30;
    localparam int unsigned     UHIE_BIT_ROOT    = 6;
    localparam int unsigned     UHIE_BIT_FRAMEWR = 5;
    localparam int unsigned     UHIE_BIT_FATAL   = 4;
    localparam int unsigned     UHIE_BIT_RESUME  = 3;
    localparam int unsigned     UHIE_BIT_FRBEGIN = 2;
    localparam int unsigned     UHIE_BIT_DONEQ   = 1;
    localparam int unsigned     UHIE_BIT_OVERRUN = 0;

    // implemented bits; everything else is reserved and reads zero
    localparam logic [31:0]     UHIE_EN_MASK     = 32'hc000_007f;
    localparam logic [31:0]     UHIE_EVT_MASK    = 32'h4000_007f;

    localparam logic [31:0]     UHIE_EN_RST      = 32'h0000_0000;
    localparam logic [31:0]     UHIE_STS_RST     = 32'h0000_0000;
    localparam logic [31:0]     UHIE_RD_RST      = 32'h0000_0000;

endpackage : uhie_pkg

// [rtl/uhie_irq_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none

// How it works
// RULE1: the interrupt request is high only while an event flag, its enable and the master enable are all set.
// RULE2: writing the enable-set register ORs each 1 into the stored enables and leaves 0 positions alone.
// RULE3: reading the enable-set register returns the stored enables and changes nothing.
// RULE4: writing the enable-clear register clears each enable written as 1 and leaves 0 positions alone.
// RULE5: reading the enable-clear register returns the same stored enables as the enable-set register.
// RULE6: bit 31 is the master gate; while it is 0 no event raises the request.
// RULE7: bit 30 enables the ownership-change event in both enable registers.
// RULE8: bits 6, 5 and 4 enable root port change, frame count wrap and fatal system error.
// RULE9: bits 3 and 2 enable resume detection and frame begin.
// RULE10: bits 1 and 0 enable done-queue writeback and scheduling overrun.
// RULE11: software writes reserved bits 29 to 7 as zero in both enable registers.
// RULE12: the enable-clear register is one 32-bit word with the enable-set layout.
// RULE13: enable-set sits at offset 10h and enable-clear at offset 14h.
// RULE14: hardware sets event flags and never clears them; software clears them by writing 1 and cannot set them.
// RULE15: the request is a level recomputed every clock and all enables reset to zero.
module uhie_irq_ctrl
    import uhie_pkg::*;
(
    input  wire logic                   i_core_clk,
    input  wire logic                   i_sys_rst,
    input  wire logic                   i_reg_wr,
    input  wire logic                   i_reg_rd,
    input  wire logic [UHIE_ADDR_W-1:0] i_reg_addr,
    input  wire logic [UHIE_DATA_W-1:0] i_reg_wdata,
    input  wire logic [UHIE_DATA_W-1:0] i_event_pulse,
    output logic      [UHIE_DATA_W-1:0] o_reg_rdata,
    output logic      [UHIE_DATA_W-1:0] o_event_flags,
    output logic      [UHIE_DATA_W-1:0] o_irq_enables,
    output logic                        o_irq_req
);

    typedef struct packed {
        logic [31:0] en;
        logic [31:0] sts;
        logic [31:0] rdata;
        logic        irq;
    } uhie_state_t;

    uhie_state_t st_r;
    uhie_state_t st_nxt;

    logic        hit_sts;
    logic        hit_set;
    logic        hit_clr;
    logic [31:0] wmask;

    function automatic logic addr_is(input logic [UHIE_ADDR_W-1:0] a, input logic [7:0] ofs);
        addr_is = (a == ofs);
    endfunction : addr_is

    assign hit_sts = addr_is(i_reg_addr, UHIE_OFS_STATUS);
    assign hit_set = addr_is(i_reg_addr, UHIE_OFS_EN_SET);  // RULE13
    assign hit_clr = addr_is(i_reg_addr, UHIE_OFS_EN_CLR);  // RULE13
    // reserved bits are dropped even if software breaks its promise
    assign wmask   = i_reg_wdata & UHIE_EN_MASK;             // RULE11 RULE12

    always_comb begin
        st_nxt = st_r;
        if (i_reg_wr && hit_set) begin
            st_nxt.en = st_r.en | wmask;                     // RULE2
        end else if (i_reg_wr && hit_clr) begin
            st_nxt.en = st_r.en & ~wmask;                    // RULE4
        end
        // a flag cleared in the same cycle its event fires stays set
        if (i_reg_wr && hit_sts) begin
            st_nxt.sts = st_r.sts & ~(i_reg_wdata & UHIE_EVT_MASK);  // RULE14
        end
        st_nxt.sts = st_nxt.sts | (i_event_pulse & UHIE_EVT_MASK);   // RULE14
        st_nxt.rdata = UHIE_RD_RST;
        if (i_reg_rd) begin
            if (hit_set || hit_clr) begin
                st_nxt.rdata = st_r.en;                      // RULE3 RULE5
            end else if (hit_sts) begin
                st_nxt.rdata = st_r.sts;
            end
        end
        // computed from next state so the request never lags the flags
        st_nxt.irq = st_nxt.en[UHIE_BIT_MASTER]
                   && |(st_nxt.sts & st_nxt.en & UHIE_EVT_MASK);    // RULE1 RULE6 RULE7 RULE8 RULE9 RULE10 RULE15
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_r.en    <= UHIE_EN_RST;                       // RULE15
            st_r.sts   <= UHIE_STS_RST;
            st_r.rdata <= UHIE_RD_RST;
            st_r.irq   <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_reg_rdata   = st_r.rdata;
    assign o_event_flags = st_r.sts;
    assign o_irq_enables = st_r.en;
    assign o_irq_req     = st_r.irq;

    a_irq_cause_match: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE1
        o_irq_req == (st_r.en[31] && |(st_r.sts & st_r.en & UHIE_EVT_MASK)))
        else $error("request does not match flags and enables");

    a_master_gate_off: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE6
        !st_r.en[31] |-> !o_irq_req)
        else $error("request raised with master gate off");

    a_owner_event_irq: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE7
        (st_r.en[31] && st_r.en[30] && st_r.sts[30]) |-> o_irq_req)
        else $error("owner change event did not raise request");

    a_upper_events_irq: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE8
        (st_r.en[31] && |(st_r.en[6:4] & st_r.sts[6:4])) |-> o_irq_req)
        else $error("event at bits 6..4 did not raise request");

    a_mid_events_irq: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE9
        (st_r.en[31] && |(st_r.en[3:2] & st_r.sts[3:2])) |-> o_irq_req)
        else $error("event at bits 3..2 did not raise request");

    a_low_events_irq: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE10
        (st_r.en[31] && |(st_r.en[1:0] & st_r.sts[1:0])) |-> o_irq_req)
        else $error("event at bits 1..0 did not raise request");

    a_set_write_or: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE2
        (i_reg_wr && hit_set) |=> st_r.en == ($past(st_r.en) | ($past(i_reg_wdata) & UHIE_EN_MASK)))
        else $error("enable-set write did not OR in ones");

    a_clr_write_and: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE4
        (i_reg_wr && hit_clr) |=> st_r.en == ($past(st_r.en) & ~$past(i_reg_wdata)))
        else $error("enable-clear write did not clear ones");

    a_set_read_back: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE3
        (i_reg_rd && !i_reg_wr && hit_set) |=> (o_reg_rdata == $past(st_r.en)) && $stable(st_r.en))
        else $error("enable-set read wrong or disturbing");

    a_clr_read_back: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE5
        (i_reg_rd && !i_reg_wr && hit_clr) |=> o_reg_rdata == $past(st_r.en))
        else $error("enable-clear read differs from enables");

    a_reserved_zero: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE12
        (st_r.en & ~UHIE_EN_MASK) == 32'h0000_0000)
        else $error("reserved enable bit stored");

    a_event_sticky: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE14
        (i_event_pulse[0] || (st_r.sts[0] && !(i_reg_wr && hit_sts && i_reg_wdata[0]))) |=> st_r.sts[0])
        else $error("event flag lost");

    a_flag_no_sw_set: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE14
        (!st_r.sts[1] && !i_event_pulse[1]) |=> !st_r.sts[1])
        else $error("event flag set without event");

    // checked without disable so the edge that ends reset is covered
    a_reset_outputs_zero: assert property (@(posedge i_core_clk) // RULE15
        $fell(i_sys_rst) |->
            (o_irq_req == 1'b0) && (o_irq_enables == UHIE_EN_RST) && (o_reg_rdata == UHIE_RD_RST))
        else $error("outputs not at reset values after reset");

    a_rdata_idle_zero: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE3
        !i_reg_rd |=> o_reg_rdata == UHIE_RD_RST)
        else $error("read data not zero outside a read");

    a_unmapped_read_zero: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE13
        (i_reg_rd && !hit_sts && !hit_set && !hit_clr) |=> o_reg_rdata == UHIE_RD_RST)
        else $error("unmapped read returned data");

    a_unmapped_write_keep: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE13
        (i_reg_wr && !hit_set && !hit_clr) |=> st_r.en == $past(st_r.en))
        else $error("enables changed by a write elsewhere");

    a_no_write_keep: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE2 RULE4
        !i_reg_wr |=> st_r.en == $past(st_r.en))
        else $error("enables changed without a write");

    a_flag_read_back: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE14
        (i_reg_rd && hit_sts) |=> o_reg_rdata == $past(st_r.sts))
        else $error("flag read differs from flags");

    a_both_reads_agree: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE5
        (i_reg_rd && (hit_set || hit_clr)) |=> o_reg_rdata == $past(o_irq_enables))
        else $error("enable reads differ between the two offsets");

    a_master_clear_quiet: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE6
        (i_reg_wr && hit_clr && i_reg_wdata[UHIE_BIT_MASTER]) |=> !o_irq_req)
        else $error("request stayed up after master gate cleared");

    a_master_fall_quiet: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE6
        $fell(st_r.en[UHIE_BIT_MASTER]) |-> !o_irq_req)
        else $error("request up while master gate falls");

    a_no_cause_quiet: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE1
        ((st_r.sts & st_r.en & UHIE_EVT_MASK) == 32'h0000_0000) |-> !o_irq_req)
        else $error("request raised with no enabled flag");

    a_flags_not_lost: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE14
        !(i_reg_wr && hit_sts) |=> (st_r.sts & $past(st_r.sts)) == $past(st_r.sts))
        else $error("flag cleared without a software write");

    a_rsvd_flags_zero: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE14
        (st_r.sts & ~UHIE_EVT_MASK) == 32'h0000_0000)
        else $error("reserved flag bit stored");

    a_clear_write_sts: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE4
        (i_reg_wr && hit_clr) |=> st_r.sts == ($past(st_r.sts) | ($past(i_event_pulse) & UHIE_EVT_MASK)))
        else $error("enable-clear write disturbed flags");

    // one set of checks per bit, so a single broken lane cannot hide behind the others
    for (genvar g = 0; g < 32; g++) begin : g_lane
        if (UHIE_EN_MASK[g]) begin : g_en
            a_bit_en_set: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE2
                (i_reg_wr && hit_set && i_reg_wdata[g]) |=> st_r.en[g])
                else $error("enable bit not set by a written one");

            a_bit_en_clear: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE4
                (i_reg_wr && hit_clr && i_reg_wdata[g]) |=> !st_r.en[g])
                else $error("enable bit not cleared by a written one");

            a_bit_en_hold: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE2 RULE4
                !(i_reg_wr && (hit_set || hit_clr) && i_reg_wdata[g]) |=> $stable(st_r.en[g]))
                else $error("enable bit changed by a written zero");

            a_bit_read_set: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE3
                (i_reg_rd && hit_set) |=> o_reg_rdata[g] == $past(st_r.en[g]))
                else $error("enable-set read bit wrong");

            a_bit_read_clr: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE5
                (i_reg_rd && hit_clr) |=> o_reg_rdata[g] == $past(st_r.en[g]))
                else $error("enable-clear read bit wrong");
        end else begin : g_rsvd
            a_bit_rsvd_en: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE11 RULE12
                !st_r.en[g])
                else $error("reserved enable bit set");

            a_bit_rsvd_read: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE11
                i_reg_rd |=> !o_reg_rdata[g])
                else $error("reserved bit read as one");
        end

        if (UHIE_EVT_MASK[g]) begin : g_evt
            // set beats clear: an event in the clear cycle must survive
            a_bit_set_wins: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE14
                i_event_pulse[g] |=> st_r.sts[g])
                else $error("event pulse did not set its flag");

            a_bit_sw_clear: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE14
                (i_reg_wr && hit_sts && i_reg_wdata[g] && !i_event_pulse[g]) |=> !st_r.sts[g])
                else $error("written one did not clear its flag");

            a_bit_no_set: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE14
                (!st_r.sts[g] && !i_event_pulse[g]) |=> !st_r.sts[g])
                else $error("flag set without its event");

            a_bit_irq_raise: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE1
                (st_r.en[UHIE_BIT_MASTER] && st_r.en[g] && st_r.sts[g]) |-> o_irq_req)
                else $error("enabled flag did not raise request");

            a_bit_irq_next: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE15
                (st_r.en[UHIE_BIT_MASTER] && st_r.en[g] && i_event_pulse[g]
                    && !(i_reg_wr && hit_clr)) |=> o_irq_req)
                else $error("request lagged an enabled event");

            a_bit_gate_off: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE6
                (!st_r.en[UHIE_BIT_MASTER] && st_r.sts[g]) |-> !o_irq_req)
                else $error("flag raised request with gate off");

            a_bit_masked_off: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE1
                (st_r.sts == (32'h1 << g) && !st_r.en[g]) |-> !o_irq_req)
                else $error("masked flag raised request");
        end else begin : g_nevt
            a_bit_rsvd_flag: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE14
                !st_r.sts[g])
                else $error("reserved flag bit set");
        end
    end

endmodule : uhie_irq_ctrl

`default_nettype wire

// [test/uhie_host_drv.sv]
`timescale 1ns/1ps
`default_nettype none
module uhie_host_drv
    import uhie_pkg::*;
(
    input  wire logic                   i_core_clk,
    output logic                        o_reg_wr,
    output logic                        o_reg_rd,
    output logic      [UHIE_ADDR_W-1:0] o_reg_addr,
    output logic      [UHIE_DATA_W-1:0] o_reg_wdata
);
    initial begin
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_addr = 8'h00;
        o_reg_wdata = 32'h0;
    end
    // one access, then an idle cycle; idle lines flip so stale values never look valid
    task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(negedge i_core_clk);
        o_reg_addr = a;
        o_reg_wdata = (a == UHIE_OFS_EN_SET || a == UHIE_OFS_EN_CLR) ? d & UHIE_EN_MASK : d;
        o_reg_wr = w;
        o_reg_rd = !w;
        @(negedge i_core_clk);
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_addr = ~o_reg_addr;
        o_reg_wdata = ~o_reg_wdata;
    endtask : access
endmodule : uhie_host_drv
`default_nettype wire

// [test/usb_host_irq_enable_mask_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module usb_host_irq_enable_mask_tb;
    import uhie_pkg::*;
    logic clk = 1'b0, rst = 1'b1, wr, rd, irq, pend = 1'b0;
    logic [7:0] addr;
    logic [31:0] evt = 32'h0, wdata, rdata, flags, ens, en_m = 32'h0, fl_m = 32'h0, lf = 32'd80;
    logic [31:0] expq[$];
    int n_fail = 0, checked = 0, cyc = 0;
    int bits[8] = '{30, 6, 5, 4, 3, 2, 1, 0};
    always #25 clk = ~clk;
    uhie_host_drv drv (.i_core_clk(clk), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr), .o_reg_wdata(wdata));
    uhie_irq_ctrl dut (.i_core_clk(clk), .i_sys_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_event_pulse(evt), .o_reg_rdata(rdata), .o_event_flags(flags),
        .o_irq_enables(ens), .o_irq_req(irq));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish
    // k: 0 write, 1 read, 2 event pulse; model follows, then outputs are compared
    task automatic act(input int k, input logic [7:0] a, input logic [31:0] d);
        if (k == 1) begin
            expq.push_back(a == UHIE_OFS_STATUS ? fl_m : (a == UHIE_OFS_EN_SET || a == UHIE_OFS_EN_CLR) ? en_m : 32'h0);
            drv.access(1'b0, a, d);
        end else if (k == 2) begin
            @(negedge clk);
            evt = d;
            @(negedge clk);
            evt = 32'h0;
            fl_m |= d & UHIE_EVT_MASK;
        end else begin
            drv.access(1'b1, a, d);
            if (a == UHIE_OFS_EN_SET) en_m |= d & UHIE_EN_MASK;
            if (a == UHIE_OFS_EN_CLR) en_m &= ~(d & UHIE_EN_MASK);
            if (a == UHIE_OFS_STATUS) fl_m &= ~d;
        end
        chk("enables", ens, en_m);
        chk("flags", flags, fl_m);
        chk("irq", {31'h0, irq}, {31'h0, en_m[31] & (|(fl_m & en_m & UHIE_EVT_MASK))});
    endtask : act
    always @(posedge clk) pend <= rd;
    always @(negedge clk) if (pend) chk("read data", rdata, expq.pop_front());
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        act(1, UHIE_OFS_EN_CLR, 32'h0);
        foreach (bits[i]) begin
            act(2, 8'h00, 32'h1 << bits[i]);
            act(0, UHIE_OFS_EN_SET, 32'h1 << bits[i]);
            act(0, UHIE_OFS_EN_SET, 32'h8000_0000);
            act(1, UHIE_OFS_EN_CLR, 32'h0);
            act(0, UHIE_OFS_EN_CLR, 32'h1 << bits[i]);
            act(0, UHIE_OFS_STATUS, 32'h1 << bits[i]);
        end
        repeat (150) begin
            lf = lfsr(lf);
            act(lf[1:0] == 2'd3 ? 2 : int'(lf[1:0]), 8'h0c + {4'h0, lf[3:2], 2'b00}, lfsr(lf));
        end
        tally_and_finish();
    end
endmodule : usb_host_irq_enable_mask_tb
`default_nettype wire
